/* File: rtl/ebcc_pkg.sv */
// Package for the external bus cycle configuration block
package ebcc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_STRAP_STATUS = 16'hF108;
    localparam logic [15:0] IDX_CFG_0 = 16'hFF0C;
    localparam logic [15:0] IDX_CFG_1 = 16'hFF14;
    localparam logic [15:0] IDX_CFG_2 = 16'hFF16;
    localparam logic [15:0] IDX_CFG_3 = 16'hFF18;
    localparam logic [15:0] IDX_CFG_4 = 16'hFF1A;
    localparam int NUM_REGIONS = 5;
    // Field layout and reset values
    localparam logic [15:0] CFG_WRITE_MASK = 16'hF6FF;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam int STRAP_LO = 8;
    localparam int STRAP_HI = 15;
    localparam int STRAP_BUS_TYPE_FIELD_LO = 16;
    localparam int STRAP_BUS_TYPE_FIELD_HI = 17;
    localparam logic [3:0] WAIT_MAX = 4'hF;
    // Half clock unit is one core clock at 200 MHz
    localparam int CORE_CLK_MHZ = 200;
    localparam int HALF_CLOCK_NS = 5;
    localparam int HALF_CLOCK_CYC = (HALF_CLOCK_NS * CORE_CLK_MHZ + 999) / 1000;
    // Bus type codes
    localparam logic [1:0] BT_8_DEMUX = 2'h0;
    localparam logic [1:0] BT_8_MUX = 2'h1;
    localparam logic [1:0] BT_16_DEMUX = 2'h2;
    localparam logic [1:0] BT_16_MUX = 2'h3;
    // Select line and segment line enables
    localparam logic [4:0] CS_EN_3 = 5'h07;
    localparam logic [4:0] CS_EN_2 = 5'h03;
    localparam logic [4:0] CS_EN_0 = 5'h00;
    localparam logic [4:0] CS_EN_5 = 5'h1F;
    localparam logic [7:0] SEG_EN_4 = 8'h0F;
    localparam logic [7:0] SEG_EN_0 = 8'h00;
    localparam logic [7:0] SEG_EN_8 = 8'hFF;
    localparam logic [7:0] SEG_EN_2 = 8'h03;

    typedef struct packed {
        logic sel_on_write;
        logic sel_on_read;
        logic handshake_polarity;
        logic handshake_enable;
        logic rsv11;
        logic window_enable;
        logic latch_stretch;
        logic rsv8;
        logic [1:0] bus_type;
        logic tristate_wait;
        logic command_delay;
        logic [3:0] cycle_wait;
    } ebcc_cfg_t;

    typedef struct packed {
        logic [2:0] clock_ratio;
        logic [1:0] segment_lines;
        logic [1:0] select_lines;
        logic write_pin_config;
    } ebcc_strap_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ALE = 6'b000010,
        ST_DLY = 6'b000100,
        ST_CMD = 6'b001000,
        ST_TRI = 6'b010000,
        ST_DONE = 6'b100000
    } ebcc_state_t;
endpackage

/* File: rtl/ebcc_top.sv */
// External bus cycle configuration and cycle shaping logic
`timescale 1ns/1ps
module ebcc_top
    import ebcc_pkg::*;
#(
    parameter int ADDR_W = 24
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [19:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Straps
    input wire logic [17:0] strap_port,
    input wire logic external_access_strap,
    // Cycle request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [2:0] req_region,
    input wire logic req_write,
    input wire logic [1:0] req_byte_en,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [15:0] req_wdata,
    // Cycle response
    output logic rsp_valid,
    output logic rsp_err,
    output logic [15:0] rsp_rdata,
    // External bus pins
    output logic ale_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic bhe_n_o,
    output logic [4:0] cs_n_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [15:0] ad_o,
    output logic ad_oe_o,
    input wire logic [15:0] ad_i,
    input wire logic ready_i
);
    if (ADDR_W != 24) begin : g_check
        $error("ebcc_top: ADDR_W must be 24");
    end

    ebcc_cfg_t cfg_q [NUM_REGIONS];
    ebcc_strap_t strap_q;
    logic init_q;
    ebcc_state_t state_q;
    ebcc_state_t state_d;
    logic [2:0] region_q;
    logic wr_q;
    logic [1:0] be_q;
    logic [ADDR_W-1:0] addr_q;
    logic [15:0] wdata_q;
    logic ale_cnt_q;
    logic [3:0] wait_cnt_q;
    logic [15:0] rdata_q;
    logic err_q;

    // APB decode
    wire logic apb_access = psel & penable;
    wire logic apb_wr = apb_access & pwrite;
    wire logic hit_strap = paddr == {2'b00, IDX_STRAP_STATUS, 2'b00};
    wire logic [4:0] hit_cfg;
    assign hit_cfg[0] = paddr == {2'b00, IDX_CFG_0, 2'b00};
    assign hit_cfg[1] = paddr == {2'b00, IDX_CFG_1, 2'b00};
    assign hit_cfg[2] = paddr == {2'b00, IDX_CFG_2, 2'b00};
    assign hit_cfg[3] = paddr == {2'b00, IDX_CFG_3, 2'b00};
    assign hit_cfg[4] = paddr == {2'b00, IDX_CFG_4, 2'b00};
    wire logic hit_any = hit_strap | (|hit_cfg);
    wire logic [15:0] cfg_rd =
        ({16{hit_cfg[0]}} & cfg_q[0]) | ({16{hit_cfg[1]}} & cfg_q[1]) |
        ({16{hit_cfg[2]}} & cfg_q[2]) | ({16{hit_cfg[3]}} & cfg_q[3]) |
        ({16{hit_cfg[4]}} & cfg_q[4]);
    wire logic [15:0] strap_rd = hit_strap ? {8'h00, strap_q} : 16'h0000;
    assign prdata = {16'h0000, cfg_rd | strap_rd};
    assign pready = 1'b1;
    // Unmapped addresses and writes to the strap register are errors
    assign pslverr = apb_access & (~hit_any | (pwrite & hit_strap));

    // Strap capture one edge after reset release
    wire ebcc_cfg_t cfg0_init = '{
        window_enable: ~external_access_strap,
        latch_stretch: ~external_access_strap,
        bus_type: external_access_strap ? 2'h0 : strap_port[STRAP_BUS_TYPE_FIELD_HI:STRAP_BUS_TYPE_FIELD_LO],
        default: 1'b0
    };

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            init_q <= 1'b1;
            strap_q <= '0;
        end else begin
            init_q <= 1'b0;
            if (init_q) begin
                strap_q <= strap_port[STRAP_HI:STRAP_LO];
            end
        end
    end

    for (genvar i = 0; i < NUM_REGIONS; i++) begin : g_cfg
        always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
                cfg_q[i] <= CFG_RESET;
            end else if (init_q && i == 0) begin
                cfg_q[i] <= cfg0_init;
            end else if (apb_wr && hit_cfg[i]) begin
                cfg_q[i] <= pwdata[15:0] & CFG_WRITE_MASK;
            end
        end
    end

    // Cycle engine
    wire logic region_ok = req_region < 3'(NUM_REGIONS);
    wire ebcc_cfg_t req_cfg = region_ok ? cfg_q[req_region] : CFG_RESET;
    wire ebcc_cfg_t cur_cfg = cfg_q[region_q];
    wire logic bus16 = cur_cfg.bus_type[1];
    wire logic muxed = cur_cfg.bus_type[0];
    wire logic ready_hit = ready_i == cur_cfg.handshake_polarity;
    wire logic cmd_end = cur_cfg.handshake_enable ? ready_hit : (wait_cnt_q == 4'h0);
    wire logic take = (state_q == ST_IDLE) & req_valid;
    wire logic refuse = ~region_ok | ~req_cfg.window_enable;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (req_valid) begin
                    state_d = refuse ? ST_DONE : ST_ALE;
                end
            end
            ST_ALE: begin
                if (!ale_cnt_q) begin
                    state_d = cur_cfg.command_delay ? ST_CMD : ST_DLY;
                end
            end
            ST_DLY: state_d = ST_CMD;
            ST_CMD: begin
                if (cmd_end) begin
                    state_d = cur_cfg.tristate_wait ? ST_DONE : ST_TRI;
                end
            end
            ST_TRI: state_d = ST_DONE;
            ST_DONE: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            region_q <= 3'h0;
            wr_q <= 1'b0;
            be_q <= 2'h0;
            addr_q <= '0;
            wdata_q <= 16'h0000;
            err_q <= 1'b0;
        end else if (take) begin
            region_q <= region_ok ? req_region : 3'h0;
            wr_q <= req_write;
            be_q <= req_byte_en;
            addr_q <= req_addr;
            wdata_q <= req_wdata;
            err_q <= refuse;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ale_cnt_q <= 1'b0;
            wait_cnt_q <= 4'h0;
            rdata_q <= 16'h0000;
        end else begin
            if (take) begin
                ale_cnt_q <= req_cfg.latch_stretch;
            end else if (state_q == ST_ALE) begin
                ale_cnt_q <= 1'b0;
            end
            if (state_q == ST_ALE) begin
                wait_cnt_q <= WAIT_MAX - cur_cfg.cycle_wait;
            end else if (state_q == ST_CMD && wait_cnt_q != 4'h0) begin
                wait_cnt_q <= wait_cnt_q - 4'h1;
            end
            if (state_q == ST_CMD && cmd_end && !wr_q) begin
                rdata_q <= bus16 ? ad_i : {8'h00, ad_i[7:0]};
            end
        end
    end

    assign req_ready = state_q == ST_IDLE;
    assign rsp_valid = state_q == ST_DONE;
    assign rsp_err = err_q;
    assign rsp_rdata = rdata_q;

    // Pin shaping
    wire logic busy = (state_q != ST_IDLE) & (state_q != ST_DONE);
    wire logic cmd_on = state_q == ST_CMD;
    wire logic split_wr = ~strap_q.write_pin_config;
    wire logic cs_gated = wr_q ? cur_cfg.sel_on_write : cur_cfg.sel_on_read;
    wire logic cs_act = cs_gated ? cmd_on : busy;
    wire logic [4:0] cs_lines =
        (strap_q.select_lines == 2'h0) ? CS_EN_3 :
        (strap_q.select_lines == 2'h1) ? CS_EN_2 :
        (strap_q.select_lines == 2'h2) ? CS_EN_0 : CS_EN_5;
    wire logic [7:0] seg_lines =
        (strap_q.segment_lines == 2'h0) ? SEG_EN_4 :
        (strap_q.segment_lines == 2'h1) ? SEG_EN_0 :
        (strap_q.segment_lines == 2'h2) ? SEG_EN_8 : SEG_EN_2;
    wire logic [4:0] region_hot = 5'h01 << region_q;

    assign ale_o = state_q == ST_ALE;
    assign rd_n_o = ~(cmd_on & ~wr_q);
    assign wr_n_o = split_wr ? ~(cmd_on & wr_q & be_q[0]) : ~(cmd_on & wr_q);
    assign bhe_n_o = split_wr ? ~(cmd_on & wr_q & be_q[1] & bus16) : ~(busy & be_q[1] & bus16);
    assign cs_n_o = ~({5{cs_act}} & region_hot & cs_lines);
    assign addr_o = {addr_q[23:16] & seg_lines, addr_q[15:0]};
    assign ad_o = (muxed && state_q == ST_ALE) ? addr_q[15:0] :
        (bus16 ? wdata_q : {8'h00, wdata_q[7:0]});
    assign ad_oe_o = (muxed & (state_q == ST_ALE)) | (wr_q & (state_q == ST_DLY | cmd_on));
endmodule

/* File: sim/ebcc_sva.sv */
// Assertion checker for the bus cycle block
`timescale 1ns/1ps
module ebcc_sva (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [19:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Cycle port
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [2:0] req_region,
    input wire logic rsp_valid,
    input wire logic rsp_err,
    // Bus pins
    input wire logic ale_o,
    input wire logic rd_n_o,
    input wire logic wr_n_o,
    input wire logic bhe_n_o,
    input wire logic ad_oe_o
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire acc = psel && penable;
    a_refuse_region: assert property (req_valid && req_ready && req_region > 3'h4 |=> rsp_valid && rsp_err)
        else $error("bad region not refused");
    a_ale_length: assert property ($rose(ale_o) |-> ##[1:2] !ale_o)
        else $error("latch strobe length");
    a_cmd_follows: assert property ($fell(ale_o) |-> ##[0:1] (!rd_n_o || !wr_n_o || !bhe_n_o))
        else $error("command late");
    a_wait_bound: assert property ($fell(rd_n_o) |-> ##[1:24] rd_n_o)
        else $error("read too long");
    a_read_float: assert property (!rd_n_o |-> !ad_oe_o)
        else $error("driving during read");
    a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid && req_ready)
        else $error("response not a pulse");
    a_strap_ro: assert property (acc && pwrite && paddr == 20'h3C420 |-> pslverr)
        else $error("strap write accepted");
    a_unmapped_error: assert property (acc && paddr == 20'h00000 |-> pslverr && prdata == 32'h0)
        else $error("unmapped accepted");
    c_read: cover property ($fell(rd_n_o));
    c_write: cover property ($fell(wr_n_o));
    c_refused: cover property (rsp_valid && rsp_err);
endmodule
bind ebcc_top ebcc_sva u_sva (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr,
    .req_valid, .req_ready, .req_region, .rsp_valid, .rsp_err, .ale_o, .rd_n_o, .wr_n_o, .bhe_n_o, .ad_oe_o);

/* File: sim/ebcc_mem.sv */
// External memory model on the parallel bus
`timescale 1ns/1ps
module ebcc_mem (
    // Bus pins
    input wire logic core_clk,
    input wire logic rd_n_o,
    input wire logic wr_n_o,
    input wire logic [23:0] addr_o,
    output logic [15:0] ad_i,
    output logic ready_i,
    // Answer shaping
    input wire logic pol,
    input wire logic [3:0] dly
);
    logic [3:0] cnt_q = 4'h0;
    logic [15:0] last_q = 16'h0000;
    wire cmd = !rd_n_o || !wr_n_o;
    assign ready_i = (cmd && cnt_q >= dly) ? pol : !pol;
    assign ad_i = !rd_n_o ? addr_o[15:0] ^ 16'h5A5A : ~last_q;
    always_ff @(posedge core_clk) begin
        cnt_q <= cmd ? cnt_q + 4'h1 : 4'h0;
        last_q <= ad_i;
    end
endmodule

/* File: sim/test_ebcc_top.sv */
// Self-checking bench for the bus cycle block
`timescale 1ns/1ps
module test_ebcc_top;
    import ebcc_pkg::*;
    logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, req_valid = 0, req_write = 0, ea = 0, pol = 0;
    logic [17:0] strap = 18'h2A700;
    logic [19:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic pready, pslverr, req_ready, rsp_valid, rsp_err, ale_o, rd_n_o, wr_n_o, bhe_n_o, ad_oe_o, ready_i, e, w;
    logic [2:0] req_region = 0;
    logic [23:0] req_addr = 0, addr_o;
    logic [15:0] rsp_rdata, ad_o, ad_i, c, dq;
    logic [4:0] cs_n_o;
    logic [15:0] cfgs [7] = '{16'h04BF, 16'h0680, 16'h44DA, 16'h843F, 16'h1470, 16'h3470, 16'h0000};
    logic [15:0] idx [5] = '{IDX_CFG_0, IDX_CFG_1, IDX_CFG_2, IDX_CFG_3, IDX_CFG_4};
    int mismatches = 0, total_checks = 0, n, cmd_n, cs_n, oe_n, ale_n, bh_n, cmd, tot;
    always #2.5 core_clk = ~core_clk;
    ebcc_top uut (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .strap_port(strap), .external_access_strap(ea), .req_valid, .req_ready, .req_region, .req_write,
        .req_byte_en(2'h3), .req_addr, .req_wdata(16'hBEEF), .rsp_valid, .rsp_err, .rsp_rdata, .ale_o,
        .rd_n_o, .wr_n_o, .bhe_n_o, .cs_n_o, .addr_o, .ad_o, .ad_oe_o, .ad_i, .ready_i);
    ebcc_mem mem (.core_clk, .rd_n_o, .wr_n_o, .addr_o, .ad_i, .ready_i, .pol, .dly(4'h3));
    function automatic logic [19:0] ra(input logic [15:0] i);
        return {2'h0, i, 2'h0};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic cyc(input logic [2:0] r);
        @(posedge core_clk);
        req_valid <= 1;
        req_region <= r;
        req_write <= w;
        req_addr <= req_addr + 24'h130203;
        do @(posedge core_clk); while (req_ready !== 1'b1);
        req_valid <= 0;
        n = 0;
        cmd_n = 0;
        cs_n = 0;
        oe_n = 0;
        ale_n = 0;
        bh_n = 0;
        dq = 16'h0000;
        do begin
            #1;
            n++;
            cmd_n += int'(!rd_n_o || !wr_n_o);
            cs_n += int'(!cs_n_o[r]);
            oe_n += int'(ad_oe_o);
            ale_n += int'(ale_o);
            bh_n += int'(!bhe_n_o);
            if (!wr_n_o) dq = ad_o;
            if (rsp_valid !== 1'b1) @(posedge core_clk);
        end while (rsp_valid !== 1'b1 && n < 60);
        check(rsp_valid, 1);
    endtask
    task automatic final_report;
        $display("Checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #20000;
        mismatches++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        sys_rst <= 0;
        apb(0, ra(IDX_STRAP_STATUS), 0);
        check(q, 32'h00A7);
        apb(0, ra(IDX_CFG_0), 0);
        check(q, 32'h0680);
        apb(1, ra(IDX_STRAP_STATUS), 0);
        check(e, 1);
        apb(0, ra(IDX_STRAP_STATUS), 0);
        check(q, 32'h00A7);
        apb(0, 20'h00000, 0);
        check(q, 0);
        apb(1, ra(IDX_CFG_3), 32'h0000FFFF);
        apb(0, ra(IDX_CFG_3), 0);
        check(q, 32'h0000F6FF);
        $display("Test straps done");
        for (int k = 0; k < 7; k++) begin
            c = cfgs[k];
            w = c[15];
            @(posedge core_clk);
            pol <= c[13];
            apb(1, ra(idx[k % 5]), {16'h0, c});
            cyc(3'(k % 5));
            cmd = c[12] ? 4 : 16 - c[3:0];
            tot = 2 + c[9] + !c[4] + cmd + !c[5];
            check(ale_n, c[10] ? 1 + c[9] : 0);
            check(addr_o, {req_addr[23:16] & 8'h0F, req_addr[15:0]});
            check(rsp_err, !c[10]);
            if (c[10]) begin
                check(n, tot);
                check(cmd_n, cmd);
                check(cs_n, (c[14] && !w || w) ? cmd : tot - 1);
                check(bh_n, c[7] ? tot - 1 : 0);
                if (w) begin
                    check(dq, c[7] ? 16'hBEEF : 16'h00EF);
                end else begin
                    check(oe_n, c[6] ? 1 + c[9] : 0);
                    check(rsp_rdata, (req_addr[15:0] ^ 16'h5A5A) & (c[7] ? 16'hFFFF : 16'h00FF));
                end
            end
        end
        w = 0;
        cyc(3'h5);
        check(rsp_err, 1);
        check(ale_n, 0);
        $display("Test cycles done");
        @(posedge core_clk);
        ea <= 1;
        strap <= 18'h05A00;
        sys_rst <= 1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 0;
        apb(0, ra(IDX_CFG_0), 0);
        check(q, 0);
        apb(0, ra(IDX_STRAP_STATUS), 0);
        check(q, 32'h005A);
        cyc(3'h0);
        check(rsp_err, 1);
        w = 1;
        apb(1, ra(IDX_CFG_1), 32'h000004BF);
        cyc(3'h1);
        check(cmd_n, 1);
        check(bh_n, 1);
        check(cs_n, 2);
        check(dq, 16'hBEEF);
        check(addr_o, {req_addr[23:16] & 8'h03, req_addr[15:0]});
        w = 0;
        apb(1, ra(IDX_CFG_2), 32'h000004BF);
        cyc(3'h2);
        check(cs_n, 0);
        check(bh_n, 0);
        check(rsp_rdata, req_addr[15:0] ^ 16'h5A5A);
        $display("Test second reset done");
        final_report();
    end
endmodule
